// *** common/ac_pkg.sv ***
// Constants, field positions, reset values and states of the converter control block.
// Assumes a host on the three or four wire serial port and a filter feeding raw words.
package ac_pkg;
    localparam int CFG_W = 24;
    localparam int POS_CODING = 23;
    localparam int FILT_HI = 22;
    localparam int FILT_LO = 12;
    localparam int MODE_HI = 11;
    localparam int MODE_LO = 9;
    localparam int POS_BIPOLAR = 8;
    localparam int GAIN_HI = 7;
    localparam int GAIN_LO = 5;
    localparam int POS_BURNOUT = 4;
    localparam int POS_STANDBY = 3;
    localparam int POS_BYTE_ORDER = 2;
    localparam int POS_BIT_ORDER = 1;
    localparam int POS_READ_LINE = 0;
    localparam logic [1:0] REG_DATA = 2'h0;
    localparam logic [1:0] REG_CFG = 2'h1;
    localparam logic [1:0] REG_OFFSET = 2'h2;
    localparam logic [2:0] MODE_CONVERT = 3'h0;
    localparam logic [2:0] MODE_SELF_CAL = 3'h1;
    localparam logic [10:0] FILT_RST = 11'h0C8;
    localparam logic [10:0] FILT_MIN = 11'h00A;
    localparam logic [23:0] CFG_RST = {1'b0, FILT_RST, MODE_SELF_CAL, 1'b1, 8'h00};
    localparam int NOTCH_DIV_LOG2 = 9;
    localparam logic [1:0] CAL_WORDS = 2'h2;
    localparam logic [1:0] SETTLE_WORDS = 2'h3;
    localparam logic [2:0] PGA_MAX_CODE = 3'h3;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESULT_READY_N_HIGH_MIN_NS = 100;
    localparam int RESULT_READY_N_HIGH_CYC_I = (RESULT_READY_N_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] RESULT_READY_N_HIGH_CYC = 3'(RESULT_READY_N_HIGH_CYC_I);
    typedef enum logic [3:0] {
        ST_STANDBY = 4'b0001,
        ST_CAL = 4'b0010,
        ST_SETTLE = 4'b0100,
        ST_RUN = 4'b1000
    } ac_state_t;
endpackage

// *** rtl/ac_link.sv ***
// Serial port logic on the host's serial clock: instruction byte, then data bytes.
// Assumes sclk only runs while cs_n is low; cs_n high clears the frame state.
`timescale 1ns/1ps
module ac_link
    import ac_pkg::*;
(
    input wire logic sclk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sdio_in,
    input wire logic [2:0] order_cfg,
    input wire logic [23:0] data_word,
    input wire logic [23:0] cfg_word,
    input wire logic [23:0] offset_word,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic wr_tgl,
    output logic [1:0] wr_reg,
    output logic [1:0] wr_byte,
    output logic [7:0] wr_data,
    output logic rd_busy
);
    logic frame_rst_n;
    logic [2:0] order_s;
    logic data_reg, data_next, done_reg, done_next, busy_reg, busy_next;
    logic lsbf_reg, lsbf_next, bd_reg, bd_next, sdl_reg, sdl_next;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] instr_reg, instr_next, sh_reg, sh_next, rx_byte;
    logic [1:0] idx_reg, idx_next, left_reg, left_next;
    logic tgl_reg, tgl_next;
    logic [1:0] wreg_reg, wreg_next, wbyte_reg, wbyte_next;
    logic [7:0] wdat_reg, wdat_next;
    logic out_reg, out_next, drv_reg, drv_next;
    logic [23:0] sel_word;
    logic [7:0] cur_byte;

    assign frame_rst_n = rst_n & ~cs_n;

    ac_sync #(.W(3)) u_order_sync (
        .clk(sclk),
        .rst_n(frame_rst_n),
        .d(order_cfg),
        .q(order_s)
    );

    assign rx_byte = lsbf_reg ? {sdio_in, sh_reg[7:1]} : {sh_reg[6:0], sdio_in};

    always_comb begin
        data_next = data_reg;
        done_next = done_reg;
        busy_next = busy_reg;
        lsbf_next = lsbf_reg;
        bd_next = bd_reg;
        sdl_next = sdl_reg;
        bit_next = bit_reg + 3'h1;
        instr_next = instr_reg;
        sh_next = rx_byte;
        idx_next = idx_reg;
        left_next = left_reg;
        tgl_next = tgl_reg;
        wreg_next = wreg_reg;
        wbyte_next = wbyte_reg;
        wdat_next = wdat_reg;
        if (!data_reg) begin
            instr_next = {instr_reg[6:0], sdio_in};
            if (bit_reg == 3'h7) begin
                data_next = 1'b1;
                idx_next = instr_next[1:0];
                left_next = instr_next[6:5];
                // Frame-local copies, so a write in this frame changes nothing until the next.
                lsbf_next = order_s[POS_BIT_ORDER];
                bd_next = order_s[POS_BYTE_ORDER];
                sdl_next = order_s[POS_READ_LINE];
                busy_next = !instr_next[7] && instr_next[3:2] == REG_DATA;
            end
        end else if (!done_reg && bit_reg == 3'h7) begin
            if (instr_reg[7]) begin
                tgl_next = ~tgl_reg;
                wreg_next = instr_reg[3:2];
                wbyte_next = idx_reg;
                wdat_next = rx_byte;
            end
            idx_next = bd_reg ? idx_reg + 2'h1 : idx_reg - 2'h1;
            left_next = left_reg - 2'h1;
            if (left_reg == 2'h0) begin
                done_next = 1'b1;
                busy_next = 1'b0;
            end
        end
    end

    always_ff @(posedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            data_reg <= 1'b0;
            done_reg <= 1'b0;
            busy_reg <= 1'b0;
            lsbf_reg <= 1'b0;
            bd_reg <= 1'b0;
            sdl_reg <= 1'b0;
            bit_reg <= 3'h0;
            instr_reg <= 8'h00;
            sh_reg <= 8'h00;
            idx_reg <= 2'h0;
            left_reg <= 2'h0;
        end else begin
            data_reg <= data_next;
            done_reg <= done_next;
            busy_reg <= busy_next;
            lsbf_reg <= lsbf_next;
            bd_reg <= bd_next;
            sdl_reg <= sdl_next;
            bit_reg <= bit_next;
            instr_reg <= instr_next;
            sh_reg <= sh_next;
            idx_reg <= idx_next;
            left_reg <= left_next;
        end
    end

    // The write toggle must survive between frames, so only the device reset clears it.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_reg <= 1'b0;
            wreg_reg <= 2'h0;
            wbyte_reg <= 2'h0;
            wdat_reg <= 8'h00;
        end else begin
            tgl_reg <= tgl_next;
            wreg_reg <= wreg_next;
            wbyte_reg <= wbyte_next;
            wdat_reg <= wdat_next;
        end
    end

    always_comb begin
        sel_word = 24'h000000;
        if (instr_reg[3:2] == REG_DATA) begin
            sel_word = data_word;
        end else if (instr_reg[3:2] == REG_CFG) begin
            sel_word = cfg_word;
        end else if (instr_reg[3:2] == REG_OFFSET) begin
            sel_word = offset_word;
        end
        cur_byte = 8'h00;
        if (idx_reg != 2'h3) begin
            cur_byte = sel_word[{idx_reg, 3'h0} +: 8];
        end
        out_next = lsbf_reg ? cur_byte[bit_reg] : cur_byte[3'h7 - bit_reg];
        drv_next = data_reg && !done_reg && !instr_reg[7];
    end

    // Read data changes on the falling edge so the host can take it on the rising one.
    always_ff @(negedge sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            out_reg <= 1'b0;
            drv_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            drv_reg <= drv_next;
        end
    end

    assign sdio_out = out_reg;
    assign serial_out_pin = out_reg;
    assign sdio_oe = drv_reg & ~sdl_reg;
    assign serial_out_oe = drv_reg & sdl_reg;
    assign wr_tgl = tgl_reg;
    assign wr_reg = wreg_reg;
    assign wr_byte = wbyte_reg;
    assign wr_data = wdat_reg;
    assign rd_busy = busy_reg;
endmodule // ac_link

// *** rtl/ac_sync.sv ***
// Three-stage input synchroniser for a bundle of independent levels.
// Assumes each bit is a level or toggle that holds for several destination clocks.
`timescale 1ns/1ps
module ac_sync
    import ac_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
    logic [W-1:0] q_next;

    // A bit changes only once the second and third stages agree.
    always_comb begin
        q_next = q_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                q_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;
endmodule // ac_sync

// *** rtl/ac_top.sv ***
// Converter control and result readout: configuration, offset, pacing, ready and buffer.
// Assumes the filter delivers a raw offset-binary word on sample_in at the oscillator clock.
`timescale 1ns/1ps
module ac_top
    import ac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_in,
    input wire logic [23:0] sample_in,
    output logic sdio_out,
    output logic sdio_oe,
    output logic serial_out_pin,
    output logic serial_out_oe,
    output logic result_ready_n,
    output logic [1:0] analog_gain_stage,
    output logic bipolar_mode,
    output logic burnout_source_enable,
    output logic modulator_clk_en,
    output logic cal_active
);
    // ============================================================
    // Serial port and crossing
    // ============================================================
    logic link_tgl, link_busy;
    logic [1:0] link_reg, link_byte;
    logic [7:0] link_data;
    logic [1:0] sync_q;
    logic [23:0] cfg_reg, cfg_next, off_reg, off_next;
    logic [23:0] dout_reg, dout_next, buf_reg, buf_next;

    ac_link u_link (
        .sclk(sclk),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .sdio_in(sdio_in),
        .order_cfg(cfg_reg[2:0]),
        .data_word(dout_reg),
        .cfg_word(cfg_reg),
        .offset_word(off_reg),
        .sdio_out(sdio_out),
        .sdio_oe(sdio_oe),
        .serial_out_pin(serial_out_pin),
        .serial_out_oe(serial_out_oe),
        .wr_tgl(link_tgl),
        .wr_reg(link_reg),
        .wr_byte(link_byte),
        .wr_data(link_data),
        .rd_busy(link_busy)
    );

    ac_sync #(.W(2)) u_sys_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d({link_tgl, link_busy}),
        .q(sync_q)
    );

    logic seen_reg, busy_reg;
    logic wr_pulse, rd_done, reading;
    // Write fields are held by the link for a whole byte time, far longer than the sync delay.
    assign wr_pulse = sync_q[1] ^ seen_reg;
    assign reading = sync_q[0];
    assign rd_done = busy_reg & ~sync_q[0];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            seen_reg <= sync_q[1];
            busy_reg <= sync_q[0];
        end
    end

    // ============================================================
    // Configuration register
    // ============================================================
    logic cfg_wr, cfg_hi_wr;
    logic standby, is_cal;
    logic [2:0] mode, gain;
    logic [10:0] filt;

    assign cfg_wr = wr_pulse && link_reg == REG_CFG && link_byte != 2'h3;
    assign cfg_hi_wr = cfg_wr && link_byte != 2'h0;

    always_comb begin
        cfg_next = cfg_reg;
        if (cfg_wr) begin
            cfg_next[{link_byte, 3'h0} +: 8] = link_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= CFG_RST;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign standby = cfg_reg[POS_STANDBY];
    assign mode = cfg_reg[MODE_HI:MODE_LO];
    assign gain = cfg_reg[GAIN_HI:GAIN_LO];
    assign filt = cfg_reg[FILT_HI:FILT_LO];
    assign is_cal = mode != MODE_CONVERT;
    assign bipolar_mode = cfg_reg[POS_BIPOLAR];
    assign burnout_source_enable = cfg_reg[POS_BURNOUT];
    assign modulator_clk_en = ~standby;
    // Codes above 3 keep the analog stage at 3 and finish the gain digitally.
    assign analog_gain_stage = (gain > PGA_MAX_CODE) ? PGA_MAX_CODE[1:0] : gain[1:0];

    // ============================================================
    // Word pacing and sequencing
    // ============================================================
    ac_state_t st_reg, st_next;
    logic [19:0] cnt_reg, cnt_next, period;
    logic [1:0] wc_reg, wc_next;
    logic tick, cal_done;
    logic [10:0] filt_eff;

    // Codes below the legal floor are clamped rather than running absurdly fast.
    assign filt_eff = (filt < FILT_MIN) ? FILT_MIN : filt;
    assign period = {filt_eff, {NOTCH_DIV_LOG2{1'b0}}};
    assign tick = (st_reg != ST_STANDBY) && cnt_reg == period - 20'h00001;

    always_comb begin
        st_next = st_reg;
        cnt_next = tick ? 20'h00000 : cnt_reg + 20'h00001;
        wc_next = wc_reg;
        cal_done = 1'b0;
        case (st_reg)
            ST_STANDBY: begin
                cnt_next = 20'h00000;
                if (!standby) begin
                    st_next = is_cal ? ST_CAL : ST_SETTLE;
                    wc_next = 2'h0;
                end
            end
            ST_CAL: begin
                if (tick) begin
                    wc_next = wc_reg + 2'h1;
                    if (wc_reg == CAL_WORDS - 2'h1) begin
                        cal_done = 1'b1;
                        st_next = ST_SETTLE;
                        wc_next = 2'h0;
                    end
                end
            end
            ST_SETTLE: begin
                if (tick) begin
                    wc_next = wc_reg + 2'h1;
                    if (wc_reg == SETTLE_WORDS - 2'h1) begin
                        st_next = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                wc_next = 2'h0;
            end
            default: begin
                st_next = ST_STANDBY;
            end
        endcase
        if (cfg_hi_wr && !standby) begin
            st_next = is_cal ? ST_CAL : ST_SETTLE;
            cnt_next = 20'h00000;
            wc_next = 2'h0;
        end
        if (standby) begin
            st_next = ST_STANDBY;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_CAL;
            cnt_reg <= 20'h00000;
            wc_reg <= 2'h0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            wc_reg <= wc_next;
        end
    end

    assign cal_active = st_reg == ST_CAL;

    // ============================================================
    // Offset correction register
    // ============================================================
    // No reset: the value is undefined until the calibration that follows reset fills it.
    always_comb begin
        off_next = off_reg;
        if (wr_pulse && link_reg == REG_OFFSET && link_byte != 2'h3) begin
            off_next[{link_byte, 3'h0} +: 8] = link_data;
        end
        if (cal_done) begin
            off_next = sample_in;
        end
    end

    always_ff @(posedge clk_sys) begin
        off_reg <= off_next;
    end

    // ============================================================
    // Result formatting
    // ============================================================
    logic [23:0] diff, scaled, result;
    logic [2:0] dshift;

    // Digital gain wraps on overflow; the host must keep inputs inside the selected range.
    always_comb begin
        diff = sample_in - off_reg;
        dshift = gain[2] ? {1'b0, gain[1:0]} + 3'h1 : 3'h0;
        scaled = diff << dshift;
        result = scaled;
        if (bipolar_mode && cfg_reg[POS_CODING]) begin
            result = {~scaled[23], scaled[22:0]};
        end
    end

    // ============================================================
    // Output register, one-word buffer and ready
    // ============================================================
    logic full_reg, full_next, valid_reg, valid_next, pend_reg, pend_next;
    logic [2:0] hold_reg, hold_next;
    logic new_word;

    assign new_word = tick && st_reg == ST_RUN;

    always_comb begin
        dout_next = dout_reg;
        buf_next = buf_reg;
        full_next = full_reg;
        valid_next = valid_reg;
        pend_next = pend_reg;
        hold_next = hold_reg;
        if (standby || cfg_hi_wr) begin
            valid_next = 1'b0;
            full_next = 1'b0;
            pend_next = 1'b0;
        end else begin
            if (rd_done) begin
                valid_next = 1'b0;
                if (full_reg) begin
                    dout_next = buf_reg;
                    full_next = 1'b0;
                    pend_next = 1'b1;
                    hold_next = RESULT_READY_N_HIGH_CYC - 3'h1;
                end
            end else if (pend_reg) begin
                if (hold_reg == 3'h0) begin
                    valid_next = 1'b1;
                    pend_next = 1'b0;
                end else begin
                    hold_next = hold_reg - 3'h1;
                end
            end
            if (new_word) begin
                if (reading || pend_next) begin
                    // The word under read stays put; a newer one replaces the buffered one.
                    buf_next = result;
                    full_next = 1'b1;
                end else begin
                    dout_next = result;
                    valid_next = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dout_reg <= 24'h000000;
            buf_reg <= 24'h000000;
            full_reg <= 1'b0;
            valid_reg <= 1'b0;
            pend_reg <= 1'b0;
            hold_reg <= 3'h0;
        end else begin
            dout_reg <= dout_next;
            buf_reg <= buf_next;
            full_reg <= full_next;
            valid_reg <= valid_next;
            pend_reg <= pend_next;
            hold_reg <= hold_next;
        end
    end

    assign result_ready_n = ~valid_reg;
endmodule // ac_top

// *** tb/ac_host.sv ***
// Host processor model on the serial port: frames, writes and reads.
// Assumes the serial clock idles low and runs only inside frames.
`timescale 1ns/1ps
module ac_host (
    output logic sclk,
    output logic cs_n,
    output logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe
);
    logic drv;
    logic last;
    assign sdio_in = sdio_oe ? sdio_out : drv;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        drv = 1'b0;
        last = 1'b0;
    end
    // Reads start at once and end well inside two word periods.
    // An undriven line shows the inverse of its last level, never a stale copy.
    task automatic xfer(input logic [7:0] ins, input int nb, input logic [31:0] wd,
                        input int stall, output logic [31:0] rd);
        logic [39:0] sh;
        logic rx;
        sh = {ins, wd << (8 * (4 - nb))};
        rd = 32'h0;
        #7 cs_n = 1'b0;
        for (int i = 0; i < 8 * (nb + 1); i++) begin
            drv = sh[39 - i];
            #16 sclk = 1'b1;
            rx = sdio_oe ? sdio_out : (serial_out_oe ? serial_out_pin : ~last);
            last = rx;
            if (i >= 8) rd = {rd[30:0], rx};
            #16 sclk = 1'b0;
            if (i == 15) #(stall);
        end
        #16 cs_n = 1'b1;
        drv = ~drv;
        #40;
    endtask
endmodule // ac_host

// *** tb/ac_properties.sv ***
// Checker for the converter control top: ready timing, enables and read pin drive.
// Assumes it is bound into ac_top and sees only its ports.
`timescale 1ns/1ps
module ac_properties (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sdio_oe,
    input wire logic serial_out_oe,
    input wire logic result_ready_n,
    input wire logic [1:0] analog_gain_stage,
    input wire logic bipolar_mode,
    input wire logic burnout_source_enable,
    input wire logic modulator_clk_en,
    input wire logic cal_active
);
    // ==========
    // Frame age
    // ==========
    // Register side effects may only follow a frame closely; age saturates at 31.
    logic [4:0] age_reg;
    logic [4:0] age_next;
    always_comb begin
        age_next = age_reg;
        if (!cs_n) age_next = 5'h00;
        else if (age_reg != 5'h1F) age_next = age_reg + 5'h01;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) age_reg <= 5'h1F;
        else age_reg <= age_next;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ==========
    // Properties
    // ==========
    a_standby_ready_high: assert property (!modulator_clk_en [*2] |-> result_ready_n)
        else $error("ready low in standby");
    a_cal_ready_high: assert property (cal_active [*2] |-> result_ready_n)
        else $error("ready low while calibrating");
    a_fall_when_run: assert property ($fell(result_ready_n) |-> !cal_active && modulator_clk_en)
        else $error("ready fell outside run");
    a_one_read_line: assert property (!(sdio_oe && serial_out_oe))
        else $error("both read lines driven");
    a_idle_no_drive: assert property (cs_n [*2] |-> !sdio_oe && !serial_out_oe)
        else $error("read line driven outside frame");
    a_ready_min_high: assert property ($rose(result_ready_n) |-> result_ready_n [*4])
        else $error("ready high time too short");
    a_read_keeps_ready: assert property ((sdio_oe || serial_out_oe) && !result_ready_n
        |=> !result_ready_n)
        else $error("ready dropped during read");
    a_rise_after_frame: assert property ($rose(result_ready_n) |-> age_reg < 5'h10)
        else $error("ready rose with no frame");
    a_modclk_after_write: assert property ($changed(modulator_clk_en) |-> age_reg < 5'h10)
        else $error("modulator enable changed with no write");
    a_cfg_after_write: assert property ($changed(analog_gain_stage)
        || $changed(bipolar_mode) || $changed(burnout_source_enable) |-> age_reg < 5'h10)
        else $error("config output changed with no write");
    c_buffer_move: cover property ($rose(result_ready_n) ##4 !result_ready_n);
    c_sep_line: cover property (serial_out_oe);
    c_standby: cover property (!modulator_clk_en);
endmodule // ac_properties
bind ac_top ac_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n),
    .sdio_oe(sdio_oe), .serial_out_oe(serial_out_oe), .result_ready_n(result_ready_n),
    .analog_gain_stage(analog_gain_stage), .bipolar_mode(bipolar_mode),
    .burnout_source_enable(burnout_source_enable), .modulator_clk_en(modulator_clk_en),
    .cal_active(cal_active));

// *** tb/tb.sv ***
// Testbench for ac_top: reset values, gain, restart pacing, buffer, standby, order.
// Assumes ac_host drives the serial port; filter code 10 keeps word periods short.
`timescale 1ns/1ps
module tb;
    import ac_pkg::*;
    logic clk_sys, rst_n, sclk, cs_n, sdio_in, sdio_out, sdio_oe, so_pin, so_oe, rdy_n;
    logic bip, burn, mod_en, cal;
    logic [1:0] gain;
    logic [23:0] sample_in;
    logic [31:0] rd;
    int err_count, samples_checked, n;
    time t0;
    ac_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .sdio_in(sdio_in), .sample_in(sample_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_out_pin(so_pin), .serial_out_oe(so_oe), .result_ready_n(rdy_n),
        .analog_gain_stage(gain), .bipolar_mode(bip), .burnout_source_enable(burn),
        .modulator_clk_en(mod_en), .cal_active(cal));
    ac_host host (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .serial_out_pin(so_pin), .serial_out_oe(so_oe));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) sample_in <= sample_in + 24'h000101;
    task automatic close_out();
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy(input logic lvl, input int lim, output int cyc);
        cyc = 0;
        while (rdy_n !== lvl) begin
            @(posedge clk_sys);
            #1;
            cyc++;
            if (cyc > lim) begin
                err_count++;
                close_out();
            end
        end
    endtask
    task automatic wr0(input logic [7:0] b);
        host.xfer(8'h84, 1, {24'h0, b}, 0, rd);
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        host.xfer(8'h46, 3, 32'h0, 0, rd);
        chk(rd, {8'h00, CFG_RST});
        chk({bip, burn, mod_en, cal, rdy_n, gain}, 7'h5C);
    endtask
    task automatic t_gain();
        for (int c = 0; c < 8; c++) begin
            wr0({3'(c), 5'h10});
            chk({burn, gain}, {1'b1, (c > 3) ? 2'h3 : 2'(c)});
        end
    endtask
    task automatic t_restart();
        host.xfer(8'hA6, 2, 32'h00A3, 0, rd);
        repeat (8) @(posedge clk_sys);
        chk({rdy_n, cal}, 2'h3);
        // Two calibration periods, three settling periods, then the first result period.
        wait_rdy(1'b0, 31000, n);
        chk(n > 30700 && n < 30720, 1);
    endtask
    task automatic t_period();
        t0 = $time;
        host.xfer(8'h42, 3, 32'h0, 0, rd);
        wait_rdy(1'b1, 20, n);
        wait_rdy(1'b0, 5300, n);
        chk((($time - t0) / 25), 5120);
        // Four periods after the offset capture, times a digital gain of sixteen.
        chk(rd, 32'h00050000);
    endtask
    task automatic t_buffer();
        host.xfer(8'h42, 3, 32'h0, 130000, rd);
        chk(rd, 32'h00464000);
        wait_rdy(1'b1, 20, n);
        wait_rdy(1'b0, 20, n);
        chk(n, 4);
        host.xfer(8'h42, 3, 32'h0, 0, rd);
        chk(rd, 32'h00878000);
    endtask
    task automatic t_standby();
        wr0(8'h08);
        chk({rdy_n, mod_en}, 2'h2);
        wr0(8'h00);
        chk({mod_en, cal}, 2'h3);
    endtask
    task automatic t_order();
        wr0(8'h07);
        host.xfer(8'h24, 2, 32'h0, 0, rd);
        chk(rd, 32'h0000E0C5);
    endtask
    initial begin
        err_count = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        sample_in = 24'h800000;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        t_reset();
        t_gain();
        t_restart();
        t_period();
        t_buffer();
        t_standby();
        t_order();
        close_out();
    end
endmodule // tb
